// ---- rtl/dhp_host_port.sv ----
// Notes on behaviour
// RQ1: style pin high selects strobe style; low selects direction style.
// RQ2: strobe style read: falling read strobe drives addressed register.
// RQ3: direction style ignores the read strobe pin completely.
// RQ4: strobe style write: low write strobe, rising edge loads data.
// RQ5: direction style: write strobe pin high reads, low writes.
// RQ6: chip select low enables the device for a transaction.
// RQ7: strobe style interrupt active high, driven only when control bit 3 set.
// RQ8: direction style interrupt is open-drain, active low, only pulls low.
// RQ9: host keeps control bit 3 clear and pulls interrupt line up.
// RQ10: transmit output idles at mark level during reset and idle.
// RQ11: software sets RTS before relying on automatic RTS flow control.
// RQ12: CTS reported in status bit 4, enables at bit 7, pulled low.
// RQ13: DSR usable as general input, DTR as general output.
// RQ14: three select lines choose one of eight registers.
// RQ15: reset high in strobe style, low in direction style, clears all.
// RQ16: chip select inactive: strobes ignored, data bus not driven.
module dhp_host_port
	import dhp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic bus_style,
	input wire logic reset_pin,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [dhp_pkg::ADDR_W-1:0] register_select_lines,
	input wire logic [dhp_pkg::DATA_W-1:0] data_in,
	output logic [dhp_pkg::DATA_W-1:0] data_out,
	output logic data_oe,
	input wire logic irq_request,
	output logic irq_out,
	output logic irq_oe,
	input wire logic tx_busy,
	input wire logic tx_bit,
	output logic tx_out,
	input wire logic cts_in,
	input wire logic dsr_in,
	output logic rts_out,
	output logic dtr_out,
	output logic auto_rts_en,
	output logic auto_cts_en
);
	import dhp_pkg::*;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam int NSYNC = 8 + ADDR_W + DATA_W;
	logic [NSYNC-1:0] sync_q;
	logic s_style;
	logic s_reset;
	logic s_cs_n;
	logic s_rd_n;
	logic s_wr_n;
	logic s_cts;
	logic s_dsr;
	logic s_busy;
	logic [ADDR_W-1:0] s_addr;
	logic [DATA_W-1:0] s_data;

	// one wide synchroniser keeps every pin except irq_request and tx_bit on the same two-cycle delay
	dhp_sync #(.W(NSYNC)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({
			bus_style,
			reset_pin,
			chip_select_n,
			read_strobe_n,
			write_strobe_n,
			cts_in,
			dsr_in,
			tx_busy,
			register_select_lines,
			data_in
		}),
		.q(sync_q)
	);
	assign {
		s_style,
		s_reset,
		s_cs_n,
		s_rd_n,
		s_wr_n,
		s_cts,
		s_dsr,
		s_busy,
		s_addr,
		s_data
	} = sync_q;

	// ----------------------------------------
	// reset pin polarity
	// ----------------------------------------
	logic pin_reset;
	logic soft_rst;
	assign pin_reset = (s_style == STYLE_STROBE) ? s_reset : !s_reset; // see RQ15
	// any cycle of an active pin clears the block; 40 ns is below one cycle
	assign soft_rst = rst || pin_reset; // see RQ15

	// ----------------------------------------
	// strobe decode
	// ----------------------------------------
	logic rd_active, wr_active;
	logic prev_rd, prev_wr;
	always_comb begin
		rd_active = 1'b0;
		wr_active = 1'b0;
		if (!s_cs_n) begin // see RQ6, RQ16
			if (s_style == STYLE_STROBE) begin // see RQ1
				rd_active = !s_rd_n; // see RQ2
				wr_active = !s_wr_n; // see RQ4
			end else begin
				// read strobe pin unused here, see RQ3
				rd_active = s_wr_n; // see RQ5
				wr_active = !s_wr_n; // see RQ5
			end
		end
	end

	always_ff @(posedge clk) begin
		if (soft_rst) begin
			prev_rd <= 1'b0;
			prev_wr <= 1'b0;
		end else begin
			prev_rd <= rd_active;
			prev_wr <= wr_active;
		end
	end

	// ----------------------------------------
	// strobe edges
	// ----------------------------------------
	logic rd_start;
	logic wr_start;
	assign rd_start = rd_active && !prev_rd;
	assign wr_start = wr_active && !prev_wr;

	// ----------------------------------------
	// transaction state
	// ----------------------------------------
	dhp_state_t state;
	dhp_state_t next_state;
	logic [ADDR_W-1:0] cap_addr;
	logic [DATA_W-1:0] cap_data;
	logic write_commit;

	always_comb begin
		next_state = state;
		write_commit = 1'b0;
		case (state)
			ST_IDLE: begin
				if (rd_start) begin
					next_state = ST_READ; // see RQ2
				end else if (wr_start) begin
					next_state = ST_WRITE; // see RQ4
				end
			end
			ST_READ: begin
				if (!rd_active) begin
					next_state = ST_IDLE;
				end
			end
			ST_WRITE: begin
				if (!wr_active) begin
					// direction style commits when the cycle ends
					write_commit = 1'b1; // see RQ4, RQ5
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (soft_rst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// data sampled while strobe held, so rising edge sees settled bus
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			cap_addr <= '0;
			cap_data <= REG_RESET;
		end else if (rd_active || wr_active) begin
			cap_addr <= s_addr; // see RQ14
			cap_data <= s_data;
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [DATA_W-1:0] regs [NUM_REGS];
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
			always_ff @(posedge clk) begin
				if (soft_rst) begin
					regs[gi] <= REG_RESET; // see RQ15
				end else if (write_commit && cap_addr == ADDR_W'(gi)) begin
					regs[gi] <= cap_data; // see RQ4, RQ14
				end
			end
		end
	endgenerate

	// live status view; the status slot shows the CTS and DSR pins in bits 4 and 5, stored bits elsewhere
	logic [DATA_W-1:0] status_view;
	always_comb begin
		status_view = regs[IDX_MODEM_STATUS];
		status_view[STATUS_CTS_BIT] = s_cts; // see RQ12
		status_view[STATUS_DSR_BIT] = s_dsr; // see RQ13
	end

	// read mux; writes to the status slot stay stored and are shown except in bits 4 and 5
	logic [DATA_W-1:0] read_byte;
	always_comb begin
		if (s_addr == IDX_MODEM_STATUS) begin
			read_byte = status_view; // see RQ12
		end else begin
			read_byte = regs[s_addr]; // see RQ14
		end
	end

	// ----------------------------------------
	// data bus drive
	// ----------------------------------------
	// enable follows the cycle; the byte stays after it for slow hosts
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			data_oe <= 1'b0;
		end else if (next_state == ST_READ) begin
			data_oe <= 1'b1; // see RQ2
		end else begin
			data_oe <= 1'b0; // see RQ16
		end
	end

	always_ff @(posedge clk) begin
		if (soft_rst) begin
			data_out <= REG_RESET;
		end else if (next_state == ST_READ) begin
			data_out <= read_byte; // see RQ2, RQ14
		end
	end

	// ----------------------------------------
	// interrupt pin
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			irq_out <= 1'b0;
			irq_oe <= 1'b0;
		end else if (s_style == STYLE_STROBE) begin
			irq_out <= irq_request; // see RQ7
			irq_oe <= regs[IDX_MODEM_CTRL][CTRL_INT_EN_BIT]; // see RQ7
		end else begin
			// open drain: output level fixed low, enable only on request
			irq_out <= 1'b0; // see RQ8
			irq_oe <= irq_request; // see RQ8
		end
	end

	// ----------------------------------------
	// modem pins
	// ----------------------------------------
	// mark is logic high here; the line driver inverts it
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			tx_out <= 1'b1; // see RQ10
		end else begin
			tx_out <= s_busy ? tx_bit : 1'b1; // see RQ10
		end
	end

	// handshake outputs are plain control bits, usable as general outputs
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			rts_out <= 1'b0;
			dtr_out <= 1'b0;
		end else begin
			rts_out <= regs[IDX_MODEM_CTRL][CTRL_RTS_BIT]; // see RQ11
			dtr_out <= regs[IDX_MODEM_CTRL][CTRL_DTR_BIT]; // see RQ13
		end
	end

	// both enables must be set; neither alone switches flow control on
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			auto_rts_en <= 1'b0;
			auto_cts_en <= 1'b0;
		end else begin
			auto_rts_en <= regs[IDX_FEATURE][FEAT_RTS_BIT] &&
				regs[IDX_INT_ENABLE][INTEN_RTS_BIT]; // see RQ11
			auto_cts_en <= regs[IDX_FEATURE][FEAT_CTS_BIT] &&
				regs[IDX_INT_ENABLE][INTEN_CTS_BIT]; // see RQ12
		end
	end
endmodule

// ---- rtl/dhp_pkg.sv ----
package dhp_pkg;
	// ----------------------------------------
	// bus styles and register selection
	// ----------------------------------------
	localparam logic STYLE_STROBE = 1'h1;
	localparam logic STYLE_DIR = 1'h0;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int NUM_REGS = 8;
	// ----------------------------------------
	// fixed register indices and bits
	// ----------------------------------------
	localparam logic [2:0] IDX_INT_ENABLE = 3'h1;
	localparam logic [2:0] IDX_MODEM_CTRL = 3'h4;
	localparam logic [2:0] IDX_MODEM_STATUS = 3'h6;
	localparam logic [2:0] IDX_FEATURE = 3'h2;
	localparam int CTRL_DTR_BIT = 0;
	localparam int CTRL_RTS_BIT = 1;
	localparam int CTRL_INT_EN_BIT = 3;
	localparam int STATUS_CTS_BIT = 4;
	localparam int STATUS_DSR_BIT = 5;
	localparam int INTEN_RTS_BIT = 6;
	localparam int INTEN_CTS_BIT = 7;
	localparam int FEAT_RTS_BIT = 6;
	localparam int FEAT_CTS_BIT = 7;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int RESET_MIN_NS = 40;
	localparam int RESET_MIN_CYC =
		(RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_WRITE = 2'b10
	} dhp_state_t;
endpackage

// ---- rtl/dhp_sync.sv ----
module dhp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] stage1;
	// stage1 is read only by q, to keep metastability contained
	always_ff @(posedge clk) begin
		if (rst) begin
			stage1 <= '0;
			q <= '0;
		end else begin
			stage1 <= d;
			q <= stage1;
		end
	end
endmodule

// ---- testbench/dhp_host_port_properties.sv ----
module dhp_host_port_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic bus_style,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic data_oe,
	input wire logic irq_request,
	input wire logic irq_out,
	input wire logic irq_oe,
	input wire logic tx_busy,
	input wire logic tx_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------
	// port properties
	// ----------------
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_idle; chip_select_n [*4] |-> !data_oe; endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_rd;
		bus_style && !chip_select_n && $fell(read_strobe_n) |-> ##3 data_oe;
	endproperty
	a_rd: assert property (p_rd) else $error("read");
	property p_hold;
		bus_style && data_oe && !read_strobe_n && !chip_select_n |=> data_oe;
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_dwr;
		(!bus_style && !write_strobe_n) [*4] |-> !data_oe;
	endproperty
	a_dwr: assert property (p_dwr) else $error("dir write");
	property p_drd;
		(!bus_style && !chip_select_n && write_strobe_n) [*4] |-> data_oe;
	endproperty
	a_drd: assert property (p_drd) else $error("dir read");
	property p_ihi; bus_style [*4] |-> irq_out == $past(irq_request); endproperty
	a_ihi: assert property (p_ihi) else $error("irq");
	property p_iod;
		!bus_style [*4] |-> !irq_out && irq_oe == $past(irq_request);
	endproperty
	a_iod: assert property (p_iod) else $error("irq od");
	property p_tx; !tx_busy [*4] |-> tx_out; endproperty
	a_tx: assert property (p_tx) else $error("tx");
	c_rd: cover property (bus_style && data_oe);
	c_drd: cover property (!bus_style && data_oe);
	c_iod: cover property (irq_oe && !irq_out);
endmodule
bind dhp_host_port dhp_host_port_checker chk (.*);

// ---- testbench/dhp_host_model.sv ----
module dhp_host_model (
	input wire logic clk,
	input wire logic bus_style,
	input wire logic data_oe,
	input wire logic [7:0] data_out,
	output logic chip_select_n = 1'h1,
	output logic read_strobe_n = 1'h1,
	output logic write_strobe_n = 1'h1,
	output logic [2:0] register_select_lines = 3'h0,
	output logic [7:0] data_in = 8'h5a
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------
	// host bus cycles
	// ----------------
	// fixed holds stand in for a ready the bus lacks
	task wr(input logic [2:0] a, input logic [7:0] d, input logic cs);
		chip_select_n <= cs;
		write_strobe_n <= 1'h0;
		read_strobe_n <= bus_style; // low only in direction style
		register_select_lines <= a;
		data_in <= d;
		repeat (4) @(posedge clk);
		if (bus_style) begin
			write_strobe_n <= 1'h1;
		end else begin
			chip_select_n <= 1'h1;
		end
		repeat (4) @(posedge clk);
		chip_select_n <= 1'h1;
		write_strobe_n <= 1'h1;
		read_strobe_n <= 1'h1;
		data_in <= ~d;
		repeat (4) @(posedge clk);
	endtask
	task rd(input logic [2:0] a, input logic cs,
		output logic [7:0] d, output logic oe);
		chip_select_n <= cs;
		register_select_lines <= a;
		read_strobe_n <= !bus_style;
		repeat (5) @(posedge clk);
		d = data_out;
		oe = data_oe;
		chip_select_n <= 1'h1;
		read_strobe_n <= 1'h1;
		repeat (5) @(posedge clk);
	endtask
endmodule

// ---- testbench/dhp_host_port_bench.sv ----
module dhp_host_port_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import dhp_pkg::*;
	// ---------
	// scenarios
	// ---------
	logic clk = 1'h0, rst = 1'h1, bus_style = 1'h1, reset_pin = 1'h0;
	logic irq_request = 1'h0, tx_busy = 1'h0, tx_bit = 1'h0;
	logic cts_in = 1'h1, dsr_in = 1'h0, oe, chip_select_n, read_strobe_n;
	logic write_strobe_n, data_oe, irq_out, irq_oe, tx_out, rts_out, dtr_out;
	logic auto_rts_en, auto_cts_en;
	logic [2:0] register_select_lines;
	logic [7:0] data_in, data_out, got;
	int mismatches = 0, tests_run = 0, cycles = 0;
	wire irq_line = irq_oe ? irq_out : 1'h1; // host pull-up
	dhp_host_port uut (.*);
	dhp_host_model host (.*);
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			wrap_up();
		end
	end
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task restart(input logic s);
		rst <= 1'h1;
		bus_style <= s;
		reset_pin <= !s;
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		repeat (4) @(posedge clk);
	endtask
	task t_regs();
		for (int i = 0; i < 8; i++) begin
			host.wr(3'(i), 8'(8'h11 * i), 1'h0);
		end
		// status reads show live pins in bits 4 and 5, the stored bits elsewhere
		for (int i = 0; i < 8; i++) begin
			host.rd(3'(i), 1'h0, got, oe);
			chk("reg", i == 6 ? 8'h56 : 8'(8'h11 * i), got);
		end
	endtask
	task t_refuse();
		host.wr(IDX_MODEM_CTRL, 8'h03, 1'h0);
		chk("pins", 8'h03, {6'h0, rts_out, dtr_out});
		host.wr(IDX_MODEM_CTRL, 8'h00, 1'h1);
		host.rd(IDX_MODEM_CTRL, 1'h1, got, oe);
		chk("deselect", 8'h03, {5'h0, oe, rts_out, dtr_out});
	endtask
	task t_flow();
		host.wr(IDX_FEATURE, 8'hc0, 1'h0); // rts already set
		host.wr(IDX_INT_ENABLE, 8'hc0, 1'h0);
		chk("auto", 8'h03, {6'h0, auto_rts_en, auto_cts_en});
		host.wr(IDX_INT_ENABLE, 8'h40, 1'h0);
		chk("auto", 8'h02, {6'h0, auto_rts_en, auto_cts_en});
	endtask
	task t_irq();
		irq_request <= 1'h1;
		host.wr(IDX_MODEM_CTRL, 8'h0b, 1'h0);
		chk("irq", 8'h03, {6'h0, irq_oe, irq_out});
		host.wr(IDX_MODEM_CTRL, 8'h03, 1'h0);
		chk("irq", 8'h01, {6'h0, irq_oe, irq_out});
		irq_request <= 1'h0;
	endtask
	task t_dir();
		restart(1'h0);
		host.wr(IDX_MODEM_CTRL, 8'h01, 1'h0); // bit 3 clear
		host.rd(IDX_MODEM_CTRL, 1'h0, got, oe);
		chk("dir", 8'h01, got);
		chk("dir oe", 8'h01, {7'h0, oe});
		irq_request <= 1'h1;
		repeat (3) @(posedge clk);
		chk("irq", 8'h01, {6'h0, irq_line, dtr_out});
		irq_request <= 1'h0;
		tx_busy <= 1'h1;
		repeat (4) @(posedge clk);
		chk("irq tx", 8'h02, {6'h0, irq_line, tx_out});
		// busy stays up, so only the reset can force mark
		reset_pin <= 1'h0;
		repeat (5) @(posedge clk);
		chk("reset", 8'h01, {6'h0, dtr_out, tx_out});
		reset_pin <= 1'h1;
		tx_busy <= 1'h0;
		repeat (4) @(posedge clk);
	endtask
	initial begin
		restart(1'h1);
		t_regs();
		t_refuse();
		t_flow();
		t_irq();
		t_dir();
		wrap_up();
	end
endmodule
